/* hw/ips_sequencer.sv */
// idle power configuration sequencer with ram sleep control and avalon slave
`timescale 1ns/1ps

// Functional notes
// [RULE_01] single ram mode from bits 3 and 2
// [RULE_02] dual ram mode from bits 1 and 0
// [RULE_03] both set active; supply only retains
// [RULE_04] software waits ten cycles after ram wake
// [RULE_05] idle command copies config into state
// [RULE_06] idle state bits gate each clock
// [RULE_07] software sets all cpu domain idle bits
// [RULE_08] memory port stays on unless usb/dma idled
// [RULE_09] software waits six cycles after gating
// [RULE_10] software flushes pipeline with six nops
// [RULE_11] software clears flags, enables wake interrupt
// [RULE_12] software drains dma before idle
// [RULE_13] light idle keeps clock generator running
// [RULE_14] deep idle exit needs pll relock time
// [RULE_15] deep idle requires usb clock off
// [RULE_16] deep idle wakes on pin, rtc, external
// [RULE_17] light idle also wakes on peripheral interrupt
// [RULE_18] wake pin used only when set input
// [RULE_19] rtc wake needs rtc interrupt enable
// [RULE_20] idle command never issued with another
// [RULE_21] wake runs isr then resumes
// [RULE_22] hardware reset discards all state
// [RULE_23] software re-enables clock generator after deep
// [RULE_24] boot leaves ports idled
// [RULE_25] ram reserved bits read zero
module ips_sequencer (
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RESET,
  // avalon-mm slave
  input  wire logic [4:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // wake sources and idle handshakes
  input  wire logic        WAKE_PIN_IN,
  input  wire logic        RTC_INT,
  input  wire logic [1:0]  EXT_INT,
  input  wire logic        PERIPH_INT,
  input  wire logic        USB_IDLED,
  input  wire logic        DMA_IDLED,
  // clock domain enables, clock generator enable and wake interrupt
  output logic      [5:0]  DOMAIN_CLK_EN,
  output logic             CLKGEN_EN,
  output logic             WAKE_IRQ,
  // ram bank state, index 0 dual, index 1 single
  output logic      [1:0]  RAM_ACCESS_OK,
  output logic      [1:0]  RAM_RETAIN,
  output logic      [1:0]  RAM_READY
);

  typedef struct packed {
    logic                 avs_wait;
    logic [31:0]          avs_rdata;
    logic [3:0]           ram_sleep;
    logic [5:0]           idle_config_reg;
    logic [5:0]           idle_state_reg;
    logic [5:0]           wake_ctrl;
    logic [5:0]           clk_en;
    logic                 wake_irq;
    ips_pkg::ips_mode_t   mode;
  } ips_state_t;

  ips_state_t st;
  ips_state_t next_st;

  logic       req;
  logic       taken;
  logic       idle_cmd;
  logic       wake_pin;
  logic       rtc_wake;
  logic       ext_wake;
  logic       periph_wake;
  logic       wake_any;

  // ==========================================================================
  // ram banks
  // ==========================================================================
  genvar b;
  generate
    for (b = 0; b < 2; b = b + 1) begin : g_bank
      ips_ram_bank u_bank (
        .clk              (CLK_SYS),
        .reset            (RESET),
        .supply_sleep_bit (st.ram_sleep[2*b+1]),   // [RULE_01] [RULE_02]
        .ground_sleep_bit (st.ram_sleep[2*b]),
        .access_ok        (RAM_ACCESS_OK[b]),
        .retain           (RAM_RETAIN[b]),
        .ready            (RAM_READY[b])
      );
    end
  endgenerate

  // ==========================================================================
  // register read decode
  // ==========================================================================
  function automatic logic [31:0] read_word(input logic [4:0] addr, input ips_state_t s,
                                            input logic [1:0] ok, input logic [1:0] rdy);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (addr)
      ips_pkg::OFS_RAM_SLEEP:  d = {28'h0000000, s.ram_sleep};      // [RULE_25]
      ips_pkg::OFS_IDLE_CFG:   d = {26'h0000000, s.idle_config_reg};
      ips_pkg::OFS_IDLE_STATE: d = {26'h0000000, s.idle_state_reg};
      ips_pkg::OFS_STATUS:     d = {26'h0000000, rdy, ok, 2'(s.mode)};
      ips_pkg::OFS_WAKE_CTRL:  d = {26'h0000000, s.wake_ctrl};
      default:                 d = 32'h0000_0000;
    endcase
    return d;
  endfunction : read_word

  // ==========================================================================
  // wake sources
  // ==========================================================================
  always_comb begin
    // pin only counts while configured as input, active high
    wake_pin    = st.wake_ctrl[ips_pkg::WAKE_PIN_DIR_BIT] & WAKE_PIN_IN;      // [RULE_16]
    rtc_wake    = st.wake_ctrl[ips_pkg::RTC_INT_EN_BIT] & RTC_INT;            // [RULE_16]
    ext_wake    = |(EXT_INT & st.wake_ctrl[ips_pkg::EXT_INT_EN_LO +: 2]);     // [RULE_16]
    // peripheral clocks may be stopped in deep idle, so that source is ignored there
    periph_wake = st.wake_ctrl[ips_pkg::PERIPH_INT_EN_BIT] & PERIPH_INT &
                  (st.mode != ips_pkg::IPS_DEEP_IDLE);                       // [RULE_17]
    wake_any    = wake_pin | rtc_wake | ext_wake | periph_wake;
  end

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb begin
    next_st          = st;
    next_st.wake_irq = 1'b0;
    req              = AVS_READ | AVS_WRITE;
    taken            = req && !st.avs_wait;
    idle_cmd         = taken && AVS_WRITE && (AVS_ADDRESS == ips_pkg::OFS_IDLE_CMD);

    // one wait cycle per access; read data is latched with the release
    if (req && st.avs_wait) begin
      next_st.avs_wait  = 1'b0;
      next_st.avs_rdata = AVS_READ ? read_word(AVS_ADDRESS, st, RAM_ACCESS_OK, RAM_READY)
                                   : 32'h0000_0000;
    end else begin
      next_st.avs_wait  = 1'b1;
    end

    if (taken && AVS_WRITE) begin
      case (AVS_ADDRESS)
        ips_pkg::OFS_RAM_SLEEP: begin
          next_st.ram_sleep = AVS_WRITEDATA[3:0];                          // [RULE_25]
        end
        ips_pkg::OFS_IDLE_CFG: begin
          next_st.idle_config_reg = AVS_WRITEDATA[5:0];
        end
        ips_pkg::OFS_WAKE_CTRL: begin
          next_st.wake_ctrl = AVS_WRITEDATA[5:0];
          // the clock generator cannot be dropped under a running light idle
          if (st.mode == ips_pkg::IPS_LIGHT_IDLE) begin
            next_st.wake_ctrl[ips_pkg::CLKGEN_EN_BIT] = 1'b1;              // [RULE_13]
          end
        end
        default: begin
        end
      endcase
    end

    case (st.mode)
      ips_pkg::IPS_ACTIVE: begin
        if (idle_cmd) begin
          next_st.idle_state_reg = st.idle_config_reg;                     // [RULE_05]
          if (st.idle_config_reg[ips_pkg::CPU_IDLE_BIT]) begin
            next_st.mode = st.wake_ctrl[ips_pkg::CLKGEN_EN_BIT] ?
                           ips_pkg::IPS_LIGHT_IDLE : ips_pkg::IPS_DEEP_IDLE;  // [RULE_13]
          end
        end
      end
      ips_pkg::IPS_LIGHT_IDLE, ips_pkg::IPS_DEEP_IDLE: begin
        // a wake returns all cpu domain clocks and raises the isr request
        if (wake_any) begin
          next_st.mode           = ips_pkg::IPS_ACTIVE;                    // [RULE_16] [RULE_17]
          next_st.idle_state_reg = 6'h00;
          next_st.wake_irq       = 1'b1;                                   // [RULE_21]
        end
      end
      default: begin
        next_st.mode = ips_pkg::IPS_ACTIVE;
      end
    endcase

    next_st.clk_en = ~next_st.idle_state_reg;                              // [RULE_06]
    if (!(USB_IDLED && DMA_IDLED)) begin
      next_st.clk_en[ips_pkg::MEMORY_PORT_IDLE_BIT] = 1'b1;                // [RULE_08]
    end
  end

  // ==========================================================================
  // state register
  // ==========================================================================
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      // everything before reset is discarded; ports start idled for boot
      st.avs_wait        <= 1'b1;                                          // [RULE_22]
      st.avs_rdata       <= 32'h0000_0000;
      st.ram_sleep       <= ips_pkg::RAM_SLEEP_RST;
      st.idle_config_reg <= ips_pkg::IDLE_CFG_RST;                         // [RULE_24]
      st.idle_state_reg  <= ips_pkg::IDLE_CFG_RST;                         // [RULE_24]
      st.wake_ctrl       <= ips_pkg::WAKE_CTRL_RST;
      st.clk_en          <= ~ips_pkg::IDLE_CFG_RST;
      st.wake_irq        <= 1'b0;
      st.mode            <= ips_pkg::IPS_ACTIVE;
    end else begin
      st <= next_st;
    end
  end

  assign AVS_READDATA    = st.avs_rdata;
  assign AVS_WAITREQUEST = st.avs_wait;
  assign DOMAIN_CLK_EN   = st.clk_en;
  assign CLKGEN_EN       = st.wake_ctrl[ips_pkg::CLKGEN_EN_BIT];
  assign WAKE_IRQ        = st.wake_irq;

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  sequence s_idle_issue;
    idle_cmd && st.mode == ips_pkg::IPS_ACTIVE;
  endsequence

  sequence s_asleep_no_source;
    st.mode == ips_pkg::IPS_DEEP_IDLE && !wake_pin && !rtc_wake && !ext_wake;
  endsequence

  idle_copy_a: assert property (s_idle_issue |=> st.idle_state_reg == $past(st.idle_config_reg)) // [RULE_05]
    else $error("idle state is not a copy of idle config");
  clock_gate_a: assert property (USB_IDLED && DMA_IDLED
                                 |=> DOMAIN_CLK_EN == ~st.idle_state_reg) // [RULE_06]
    else $error("domain clock enables do not follow idle state");
  memory_port_hold_a: assert property (!(USB_IDLED && DMA_IDLED)
                                 |=> DOMAIN_CLK_EN[ips_pkg::MEMORY_PORT_IDLE_BIT]) // [RULE_08]
    else $error("memory port idled while usb or dma active");
  light_clkgen_a: assert property (st.mode == ips_pkg::IPS_LIGHT_IDLE |-> CLKGEN_EN) // [RULE_13]
    else $error("clock generator stopped in light idle");
  deep_sleep_a: assert property (s_asleep_no_source |=> st.mode == ips_pkg::IPS_DEEP_IDLE) // [RULE_16]
    else $error("deep idle left without a deep wake source");
  periph_wake_a: assert property (st.mode == ips_pkg::IPS_LIGHT_IDLE && periph_wake
                                  |=> st.mode == ips_pkg::IPS_ACTIVE && WAKE_IRQ) // [RULE_17]
    else $error("peripheral interrupt did not end light idle");
  isr_entry_a: assert property (st.mode != ips_pkg::IPS_ACTIVE ##1 st.mode == ips_pkg::IPS_ACTIVE
                                |-> WAKE_IRQ ##1 !WAKE_IRQ) // [RULE_21]
    else $error("wake without a single isr request pulse");
  idle_enter_a: assert property (s_idle_issue ##0 st.idle_config_reg[ips_pkg::CPU_IDLE_BIT]
                                 |=> st.mode != ips_pkg::IPS_ACTIVE
                                     && !DOMAIN_CLK_EN[ips_pkg::CPU_IDLE_BIT]) // [RULE_06]
    else $error("cpu clock still running after idle command");
  bus_answer_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
                                 |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
    else $error("avalon slave did not answer in one cycle");

endmodule : ips_sequencer

/* pkg/ips_pkg.sv */
// constants, field layout and mode type of the idle power configuration sequencer
package ips_pkg;

  // ==========================================================================
  // register byte offsets on the avalon slave
  // ==========================================================================
  localparam logic [4:0] OFS_RAM_SLEEP  = 5'h00;
  localparam logic [4:0] OFS_IDLE_CFG   = 5'h04;
  localparam logic [4:0] OFS_IDLE_STATE = 5'h08;
  localparam logic [4:0] OFS_IDLE_CMD   = 5'h0C;
  localparam logic [4:0] OFS_STATUS     = 5'h10;
  localparam logic [4:0] OFS_WAKE_CTRL  = 5'h14;

  // ==========================================================================
  // ram sleep control fields
  // ==========================================================================
  localparam int         RAM_W                = 4;
  localparam int         DUAL_RAM_GROUND_BIT  = 0;
  localparam int         DUAL_RAM_SUPPLY_BIT  = 1;
  localparam int         SINGLE_RAM_GROUND_BIT = 2;
  localparam int         SINGLE_RAM_SUPPLY_BIT = 3;
  localparam logic [3:0] RAM_SLEEP_RST        = 4'hF;
  localparam logic [3:0] RAM_SETTLE_CYCLES    = 4'hA;

  // ==========================================================================
  // idle configuration / idle state fields
  // ==========================================================================
  localparam int         IDLE_W                   = 6;
  localparam int         CPU_IDLE_BIT             = 0;
  localparam int         COPROCESSOR_IDLE_BIT     = 1;
  localparam int         DATA_PORT_IDLE_BIT       = 2;
  localparam int         MEMORY_PORT_IDLE_BIT     = 3;
  localparam int         INSTRUCTION_PORT_IDLE_BIT = 4;
  localparam int         EXTERNAL_PORT_IDLE_BIT   = 5;
  localparam logic [5:0] IDLE_CFG_RST             = 6'h3E;

  // ==========================================================================
  // wake control fields
  // ==========================================================================
  localparam int         WAKE_W            = 6;
  localparam int         WAKE_PIN_DIR_BIT  = 0;
  localparam int         RTC_INT_EN_BIT    = 1;
  localparam int         EXT_INT_EN_LO     = 2;
  localparam int         PERIPH_INT_EN_BIT = 4;
  localparam int         CLKGEN_EN_BIT     = 5;
  localparam logic [5:0] WAKE_CTRL_RST     = 6'h20;

  // ==========================================================================
  // power configurations
  // ==========================================================================
  typedef enum logic [1:0] {
    IPS_ACTIVE,
    IPS_LIGHT_IDLE,
    IPS_DEEP_IDLE
  } ips_mode_t;

endpackage : ips_pkg

/* hw/ips_ram_bank.sv */
// power mode decode and wake settle tracking for one on-chip ram bank
`timescale 1ns/1ps

module ips_ram_bank (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // sleep control bits
  input  wire logic supply_sleep_bit,
  input  wire logic ground_sleep_bit,
  // bank state
  output logic      access_ok,
  output logic      retain,
  output logic      ready
);

  typedef struct packed {
    logic       access_ok;
    logic       retain;
    logic       ready;
    logic [3:0] settle;
  } ips_bank_t;

  ips_bank_t st;
  ips_bank_t next_st;

  // ==========================================================================
  // mode decode
  // ==========================================================================
  always_comb begin
    next_st = st;
    next_st.access_ok = supply_sleep_bit & ground_sleep_bit;   // [RULE_01] [RULE_02] [RULE_03]
    next_st.retain    = supply_sleep_bit & ~ground_sleep_bit;  // [RULE_03]
    // settle count restarts whenever the bank leaves active mode
    // counting from the registered state makes ready rise a full settle span after access_ok
    if (!st.access_ok) begin
      next_st.settle = 4'h0;
    end else if (st.settle != ips_pkg::RAM_SETTLE_CYCLES) begin
      next_st.settle = st.settle + 4'h1;                       // [RULE_04]
    end
    next_st.ready = next_st.access_ok && (next_st.settle == ips_pkg::RAM_SETTLE_CYCLES);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st <= '{access_ok: 1'b1, retain: 1'b0, ready: 1'b1, settle: ips_pkg::RAM_SETTLE_CYCLES};
    end else begin
      st <= next_st;
    end
  end

  assign access_ok = st.access_ok;
  assign retain    = st.retain;
  assign ready     = st.ready;

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  bank_mode_a: assert property (access_ok == $past(supply_sleep_bit && ground_sleep_bit)) // [RULE_01]
    else $error("bank access does not follow both sleep bits");
  retain_block_a: assert property (retain |-> !access_ok && !ready) // [RULE_03]
    else $error("retained bank is accessible");
  settle_wait_a: assert property ($rose(access_ok) |-> !ready [*5] ##1 !ready [*5]) // [RULE_04]
    else $error("bank ready sooner than settle time");

endmodule : ips_ram_bank

/* verification/ips_wake_model.sv */
// wake sources and controller idle handshakes facing the sequencer
`timescale 1ns/1ps

module ips_wake_model (
  // clock
  input  wire logic       clk,
  // wake sources, index 0 pin 1 rtc 2 ext a 3 ext b 4 peripheral
  output logic            wake_pin,
  output logic            rtc_int,
  output logic [1:0]      ext_int,
  output logic            periph_int,
  // controller idle handshakes
  output logic            usb_idled,
  output logic            dma_idled
);
  logic [4:0] src_level;

  // ==========================================================================
  // source levels
  // ==========================================================================
  initial begin
    src_level = 5'h00;
    usb_idled = 1'h1;
    dma_idled = 1'h1;
  end
  assign wake_pin   = src_level[0];  // pin only as an active high input
  assign rtc_int    = src_level[1];
  assign ext_int    = src_level[3:2];
  assign periph_int = src_level[4];

  // lag lets a source answer slowly; sources fall back to low after hold
  task automatic pulse(input int src, input int lag, input int hold);
    @(posedge clk);
    repeat (lag) @(posedge clk);
    src_level[src] <= 1'h1;  // wake interrupt raised only after flags were cleared
    repeat (hold) @(posedge clk);
    src_level[src] <= 1'h0;
  endtask : pulse

  // usb clock stopped before deep idle; t_light enters idle with dma still busy to hold the memory port
  task automatic set_idled(input logic usb, input logic dma);
    @(posedge clk);
    usb_idled <= usb;
    dma_idled <= dma;
  endtask : set_idled
endmodule : ips_wake_model

/* verification/test_idle_power_config_sequencer.sv */
// self-checking bench for the idle power configuration sequencer
`timescale 1ns/1ps

module test_idle_power_config_sequencer;
  // ==========================================================================
  // design pins and bookkeeping
  // ==========================================================================
  logic        clk_sys, reset, avs_read, avs_write, avs_waitrequest;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic        wake_pin_in, rtc_int, periph_int, usb_idled, dma_idled;
  logic        clkgen_en, wake_irq;
  logic [1:0]  ext_int, ram_access_ok, ram_retain, ram_ready;
  logic [5:0]  domain_clk_en;
  int          errors, n_compared, n_wake;
  logic [31:0] q;

  ips_sequencer ips_sequencer_i (.CLK_SYS(clk_sys), .RESET(reset),
    .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
    .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_waitrequest), .WAKE_PIN_IN(wake_pin_in), .RTC_INT(rtc_int),
    .EXT_INT(ext_int), .PERIPH_INT(periph_int), .USB_IDLED(usb_idled),
    .DMA_IDLED(dma_idled), .DOMAIN_CLK_EN(domain_clk_en), .CLKGEN_EN(clkgen_en),
    .WAKE_IRQ(wake_irq), .RAM_ACCESS_OK(ram_access_ok), .RAM_RETAIN(ram_retain),
    .RAM_READY(ram_ready));

  ips_wake_model ips_wake_model_i (.clk(clk_sys), .wake_pin(wake_pin_in),
    .rtc_int(rtc_int), .ext_int(ext_int), .periph_int(periph_int),
    .usb_idled(usb_idled), .dma_idled(dma_idled));

  initial begin
    clk_sys = 1'h0;
    forever #10 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (wake_irq === 1'h1) n_wake++;
  end

  // ==========================================================================
  // shared tasks
  // ==========================================================================
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic conclude();
    if (errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude

  // request held until waitrequest is sampled low, then released
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 50);
    if (n >= 50) errors++;
    q = avs_readdata;
    avs_write <= 1'h0;
    avs_read  <= 1'h0;
  endtask : bus

  task automatic rd_chk(input string what, input logic [4:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h0);
    chk(what, q, exp);
  endtask : rd_chk

  task automatic enter_idle(input logic [31:0] wake);
    bus(1'h1, ips_pkg::OFS_WAKE_CTRL, wake);  // wake sources armed
    bus(1'h1, ips_pkg::OFS_IDLE_CFG, 32'h3F);  // whole cpu domain idled
    repeat (6) @(posedge clk_sys);  // gating settle and pipeline flush
    bus(1'h1, ips_pkg::OFS_IDLE_CMD, 32'h0);  // idle command issued alone
    #1;
  endtask : enter_idle

  task automatic expect_wake(input int src, input int lag);
    int n, w;
    w = n_wake;
    n = 0;
    fork
      ips_wake_model_i.pulse(src, lag, 2);
    join_none
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (n_wake == w && n < 30);
    chk("wake seen", n < 30, 1'h1);
    chk("wake pulse width", wake_irq, 1'h0);
    chk("clocks after wake", domain_clk_en, 6'h3F);
    rd_chk("status after wake", ips_pkg::OFS_STATUS, 32'h3C);
  endtask : expect_wake

  // ==========================================================================
  // scenarios
  // ==========================================================================
  task automatic t_reset();
    chk("boot clocks", domain_clk_en, 6'h01);
    bus(1'h1, ips_pkg::OFS_IDLE_STATE, 32'h0);  // read-only register ignores writes
    rd_chk("boot idle state", ips_pkg::OFS_IDLE_STATE, 32'h3E);
    rd_chk("ram reset", ips_pkg::OFS_RAM_SLEEP, 32'hF);
    rd_chk("unmapped", 5'h18, 32'h0);
  endtask : t_reset

  task automatic t_ram();
    logic [31:0] v [4] = '{32'hFFFF_FFF0, 32'hA, 32'hB, 32'hE};
    int n;
    foreach (v[i]) begin
      bus(1'h1, ips_pkg::OFS_RAM_SLEEP, v[i]);
      @(posedge clk_sys);
      #1;
      chk("ram access", ram_access_ok, {v[i][3] & v[i][2], v[i][1] & v[i][0]});
      chk("ram retain", ram_retain, {v[i][3] & ~v[i][2], v[i][1] & ~v[i][0]});
      rd_chk("ram readback", ips_pkg::OFS_RAM_SLEEP, v[i] & 32'hF);
    end
    bus(1'h1, ips_pkg::OFS_RAM_SLEEP, 32'hF);
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (ram_ready !== 2'h3 && n < 30);
    chk("ram settle cycles", n, 11);  // no access before the bank has settled
  endtask : t_ram

  task automatic t_light();
    ips_wake_model_i.set_idled(1'h1, 1'h0);
    enter_idle(32'h3F);
    chk("port held by dma", domain_clk_en, 6'h08);
    chk("clkgen in light", clkgen_en, 1'h1);
    rd_chk("idle state copy", ips_pkg::OFS_IDLE_STATE, 32'h3F);
    rd_chk("light mode", ips_pkg::OFS_STATUS, 32'h3D);
    bus(1'h1, ips_pkg::OFS_WAKE_CTRL, 32'h1F);
    rd_chk("clkgen kept in light", ips_pkg::OFS_WAKE_CTRL, 32'h3F);
    ips_wake_model_i.set_idled(1'h1, 1'h1);
    repeat (2) @(posedge clk_sys);
    #1;
    chk("all gated", domain_clk_en, 6'h00);
    expect_wake(4, 3);
  endtask : t_light

  task automatic t_deep();
    int w;
    enter_idle(32'h1E);
    chk("clkgen in deep", clkgen_en, 1'h0);
    rd_chk("deep mode", ips_pkg::OFS_STATUS, 32'h3E);
    w = n_wake;
    fork
      ips_wake_model_i.pulse(0, 0, 3);
      ips_wake_model_i.pulse(4, 0, 3);
    join
    repeat (6) @(posedge clk_sys);
    chk("no wake in deep", n_wake, w);
    expect_wake(1, 0);
    for (int s = 0; s < 4; s++) begin
      enter_idle(32'h1F);
      expect_wake(s, s * 4);
    end
    bus(1'h1, ips_pkg::OFS_WAKE_CTRL, 32'h3F);
    @(posedge clk_sys);
    #1;
    chk("clkgen restored", clkgen_en, 1'h1);
  endtask : t_deep

  task automatic t_mid_reset();
    enter_idle(32'h3F);
    @(posedge clk_sys);
    reset <= 1'h1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'h0;
    #1;
    chk("reset clocks", domain_clk_en, 6'h01);
    rd_chk("reset idle state", ips_pkg::OFS_IDLE_STATE, 32'h3E);
    rd_chk("reset wake ctrl", ips_pkg::OFS_WAKE_CTRL, 32'h20);
  endtask : t_mid_reset

  // ==========================================================================
  // main sequence and watchdog
  // ==========================================================================
  initial begin
    errors = 0;
    n_compared = 0;
    n_wake = 0;
    reset = 1'h1;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    repeat (16) @(posedge clk_sys);
    reset <= 1'h0;
    #1;
    t_reset();
    t_ram();
    t_light();
    t_deep();
    t_mid_reset();
    conclude();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    conclude();
  end
endmodule : test_idle_power_config_sequencer
